// ---- logic/acb_regs.svh ----
// register map, field positions and reset values of the adc config block
// Operation
// - two-bit positive reference code selects source
// - negative reference bit set selects external pin
// - offset calibration ties sample-hold inputs to ground
// - buffer enable stores results by channel, else fifo
// - scan enable steps through selected mux inputs
`ifndef ACB_REGS_SVH
`define ACB_REGS_SVH

// ==========================================================
// byte addresses on apb
`define ACB_ADDR_CTRL 12'h000
`define ACB_ADDR_INCFG 12'h004
`define ACB_ADDR_STAT 12'h008
`define ACB_ADDR_BUF_FIRST 12'h040
`define ACB_ADDR_BUF_LAST 12'h07c

// ==========================================================
// converter_control_two fields
`define ACB_POS_REF_MSB 15
`define ACB_POS_REF_LSB 14
`define ACB_NEG_REF_BIT 13
`define ACB_OFFSET_CAL_BIT 12
`define ACB_BUF_IDX_BIT 11
`define ACB_SCAN_BIT 10
`define ACB_CTRL_MASK 32'h0000_fc00
`define ACB_CTRL_RESET 32'h0000_0000

// ==========================================================
// input configuration fields
`define ACB_SINGLE_LSB 0
`define ACB_MASK_LSB 16
`define ACB_INCFG_RESET 32'h0000_0000

// ==========================================================
// status fields
`define ACB_STAT_CHAN_LSB 0
`define ACB_STAT_PTR_LSB 8
`define ACB_ONEHOT_RESET 4'h1

`endif

// ---- logic/acb_pkg.sv ----
// types shared by the adc reference and buffer configuration block
package acb_pkg;

  // ==========================================================
  // positive reference source codes
  typedef enum logic [1:0] {
    ACB_REF_SUPPLY = 2'b00,
    ACB_REF_EXT = 2'b01,
    ACB_REF_BG2 = 2'b10,
    ACB_REF_BG4 = 2'b11
  } acb_pos_ref_t;

  // ==========================================================
  // result buffer organisation
  typedef enum logic {
    ACB_BUF_FIFO = 1'b0,
    ACB_BUF_INDEXED = 1'b1
  } acb_buf_mode_t;

endpackage

// ---- logic/acb_buf.sv ----
// conversion result buffer, channel indexed or fifo ordered
`timescale 1ns/100ps

module acb_buf #(
  parameter int W = 12,
  parameter int D = 16,
  parameter int AW = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire acb_pkg::acb_buf_mode_t i_mode,
  input wire logic i_wr_valid,
  input wire logic [W-1:0] i_wr_data,
  input wire logic [AW-1:0] i_wr_chan,
  input wire logic [AW-1:0] i_rd_idx,
  output logic [W-1:0] o_rd_data,
  output logic [AW-1:0] o_wr_ptr
);

  // ==========================================================
  // storage and fifo pointer
  logic [W-1:0] slot_q [D]; // result slots
  logic [AW-1:0] ptr_q; // next fifo slot
  logic [AW-1:0] ptr_d;
  logic [AW-1:0] wr_idx; // slot taken by this write
  logic indexed;

  assign indexed = (i_mode == acb_pkg::ACB_BUF_INDEXED);
  // indexed mode files by channel, fifo mode by arrival
  assign wr_idx = indexed ? i_wr_chan : ptr_q;
  // pointer parks at zero while indexed so fifo restarts clean
  assign ptr_d = indexed ? '0 :
    (i_wr_valid ? ((ptr_q == AW'(D - 1)) ? '0 : ptr_q + 1'b1) : ptr_q);
  assign o_rd_data = slot_q[i_rd_idx];
  assign o_wr_ptr = ptr_q;

  // pointer register
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ptr_q <= '0;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // slot write, one slot per result
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < D; i++) begin
        slot_q[i] <= '0;
      end
    end else if (i_wr_valid) begin
      slot_q[wr_idx] <= i_wr_data;
    end
  end

  // ==========================================================
  // checks
  slot_by_chan_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_wr_valid && indexed |=> slot_q[$past(i_wr_chan)] == $past(i_wr_data))
    else $error("indexed result not in its channel slot");

  fifo_advance_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_wr_valid && !indexed |=>
      ptr_q == AW'(($past(ptr_q) + 1) % D) &&
      slot_q[$past(ptr_q)] == $past(i_wr_data))
    else $error("fifo write did not land at pointer");

endmodule

// ---- logic/acb_scan.sv ----
// positive input mux channel sequencer, single input or scan
`timescale 1ns/100ps

module acb_scan #(
  parameter int N = 16,
  parameter int CW = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_scan_en,
  input wire logic [CW-1:0] i_single_chan,
  input wire logic [N-1:0] i_scan_mask,
  input wire logic i_conv_done,
  output logic [CW-1:0] o_chan
);

  // ==========================================================
  // next selected input after cur, wrapping; stays if none
  function automatic logic [CW-1:0] next_sel(
    input logic [CW-1:0] cur,
    input logic [N-1:0] mask
  );
    logic [CW-1:0] pick;
    logic [CW-1:0] cand;
    logic found;
    pick = cur;
    found = 1'b0;
    for (int k = 1; k <= N; k++) begin
      cand = CW'((int'(cur) + k) % N);
      if (!found && mask[cand]) begin
        pick = cand;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  logic [CW-1:0] chan_q; // channel now on mux a
  logic [CW-1:0] chan_d;

  // scan starts from the single channel, steps on each result
  assign chan_d = !i_scan_en ? i_single_chan :
    (i_conv_done ? next_sel(chan_q, i_scan_mask) : chan_q);
  assign o_chan = chan_q;

  // channel register
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      chan_q <= '0;
    end else begin
      chan_q <= chan_d;
    end
  end

  // ==========================================================
  // checks
  single_hold_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    !i_scan_en ##1 !i_scan_en |-> chan_q == $past(i_single_chan))
    else $error("single input mode left configured input");

  scan_step_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    i_scan_en && i_conv_done |=>
      chan_q == next_sel($past(chan_q), $past(i_scan_mask)))
    else $error("scan did not step to next selected input");

endmodule

// ---- logic/acb_top.sv ----
// apb register file and reference, calibration, buffer and scan control
`timescale 1ns/100ps
`include "acb_regs.svh"

module acb_top #(
  parameter int NCH = 16,
  parameter int CW = 4,
  parameter int RW = 12
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_result_valid,
  input wire logic [RW-1:0] i_result,
  input wire logic i_conv_done,
  output logic [3:0] o_pos_ref_onehot,
  output logic o_neg_ref_ext,
  output logic o_sh_to_ground,
  output logic o_sh_normal,
  output logic o_buf_indexed,
  output logic o_scan_active,
  output logic [CW-1:0] o_mux_a_chan
);

  // ==========================================================
  // byte-lane merge of a write into an old word
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old,
    input logic [31:0] wdat,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================
  // state
  logic [31:0] ctrl_q; // converter_control_two, upper bits only
  logic [31:0] ctrl_d;
  logic [31:0] incfg_q; // single input and scan mask
  logic [31:0] incfg_d;
  logic pready_q; // answer strobe
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [3:0] onehot_q; // decoded positive reference
  logic neg_ext_q;
  logic sh_gnd_q;
  logic sh_norm_q;
  logic buf_idx_q;
  logic scan_q;

  // ==========================================================
  // apb decode
  logic access; // access phase not yet answered
  logic wr_acc;
  logic rd_acc;
  logic hit_ctrl;
  logic hit_incfg;
  logic hit_stat;
  logic hit_buf;
  logic mapped;
  logic err;
  logic [CW-1:0] buf_rd_idx;
  logic [RW-1:0] buf_rd_data;
  logic [CW-1:0] wr_ptr;
  logic [CW-1:0] chan;
  logic [31:0] rd_word;
  logic [31:0] stat_word;
  logic [1:0] pos_code;
  acb_pkg::acb_buf_mode_t buf_mode;

  // pready is registered: one wait state, then the answer
  assign access = i_psel & i_penable & ~pready_q;
  assign wr_acc = access & i_pwrite;
  assign rd_acc = access & ~i_pwrite;
  assign hit_ctrl = (i_paddr == `ACB_ADDR_CTRL);
  assign hit_incfg = (i_paddr == `ACB_ADDR_INCFG);
  assign hit_stat = (i_paddr == `ACB_ADDR_STAT);
  assign hit_buf = (i_paddr >= `ACB_ADDR_BUF_FIRST) &&
    (i_paddr <= `ACB_ADDR_BUF_LAST) && (i_paddr[1:0] == 2'b00);
  assign mapped = hit_ctrl | hit_incfg | hit_stat | hit_buf;
  // status and slots are read only; writing them is an error
  assign err = ~mapped | (i_pwrite & (hit_stat | hit_buf));
  assign buf_rd_idx = i_paddr[CW+1:2];

  // only the implemented control bits can ever be stored
  assign ctrl_d = (wr_acc && hit_ctrl) ?
    (lane_merge(ctrl_q, i_pwdata, i_pstrb) & `ACB_CTRL_MASK) :
    ctrl_q;
  assign incfg_d = (wr_acc && hit_incfg) ?
    lane_merge(incfg_q, i_pwdata, i_pstrb) : incfg_q;

  assign stat_word = (32'(chan) << `ACB_STAT_CHAN_LSB) |
    (32'(wr_ptr) << `ACB_STAT_PTR_LSB);
  // bits 9:8 and all unmapped reads come back zero
  assign rd_word = hit_ctrl ? (ctrl_q & `ACB_CTRL_MASK) :
    hit_incfg ? incfg_q :
    hit_stat ? stat_word :
    hit_buf ? 32'(buf_rd_data) : 32'h0000_0000;

  // ==========================================================
  // control field views
  assign pos_code = ctrl_q[`ACB_POS_REF_MSB:`ACB_POS_REF_LSB];
  assign buf_mode = acb_pkg::acb_buf_mode_t'(ctrl_q[`ACB_BUF_IDX_BIT]);

  // apb answer registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= access;
      pslverr_q <= access & err;
      prdata_q <= rd_acc ? rd_word : 32'h0000_0000;
    end
  end

  // software registers, cleared at reset
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= `ACB_CTRL_RESET;
      incfg_q <= `ACB_INCFG_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      incfg_q <= incfg_d;
    end
  end

  // reference decode: one select line per source
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      onehot_q <= `ACB_ONEHOT_RESET; // analog supply after reset
      neg_ext_q <= 1'b0;
    end else begin
      onehot_q <= 4'h1 << pos_code;
      neg_ext_q <= ctrl_q[`ACB_NEG_REF_BIT];
    end
  end

  // sample-hold routing and mode flags
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sh_gnd_q <= 1'b0;
      sh_norm_q <= 1'b1;
      buf_idx_q <= 1'b0;
      scan_q <= 1'b0;
    end else begin
      sh_gnd_q <= ctrl_q[`ACB_OFFSET_CAL_BIT];
      sh_norm_q <= ~ctrl_q[`ACB_OFFSET_CAL_BIT];
      buf_idx_q <= ctrl_q[`ACB_BUF_IDX_BIT];
      scan_q <= ctrl_q[`ACB_SCAN_BIT];
    end
  end

  // ==========================================================
  // result buffer; results carry the channel now on mux a
  acb_buf #(
    .W(RW),
    .D(NCH),
    .AW(CW)
  ) u_buf (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_mode(buf_mode),
    .i_wr_valid(i_result_valid),
    .i_wr_data(i_result),
    .i_wr_chan(chan),
    .i_rd_idx(buf_rd_idx),
    .o_rd_data(buf_rd_data),
    .o_wr_ptr(wr_ptr)
  );

  // mux a sequencer
  acb_scan #(
    .N(NCH),
    .CW(CW)
  ) u_scan (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_scan_en(ctrl_q[`ACB_SCAN_BIT]),
    .i_single_chan(incfg_q[`ACB_SINGLE_LSB +: CW]),
    .i_scan_mask(incfg_q[`ACB_MASK_LSB +: NCH]),
    .i_conv_done(i_conv_done),
    .o_chan(chan)
  );

  // ==========================================================
  // outputs
  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_pos_ref_onehot = onehot_q;
  assign o_neg_ref_ext = neg_ext_q;
  assign o_sh_to_ground = sh_gnd_q;
  assign o_sh_normal = sh_norm_q;
  assign o_buf_indexed = buf_idx_q;
  assign o_scan_active = scan_q;
  assign o_mux_a_chan = chan;

  // ==========================================================
  // checks
  sequence apb_access_s;
    i_psel && i_penable && !pready_q;
  endsequence

  sequence ctrl_read_s;
    apb_access_s and (!i_pwrite && hit_ctrl);
  endsequence

  apb_answer_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    apb_access_s |=> pready_q ##1 !pready_q)
    else $error("apb answer not exactly one cycle after access");

  pos_ref_map_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    ##1 (onehot_q == (4'h1 << $past(pos_code))) && $onehot(onehot_q))
    else $error("positive reference select wrong");

  neg_ref_map_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    ##1 neg_ext_q == $past(ctrl_q[`ACB_NEG_REF_BIT]))
    else $error("negative reference select wrong");

  offset_cal_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    ##1 (sh_gnd_q == $past(ctrl_q[`ACB_OFFSET_CAL_BIT])) &&
      (sh_gnd_q != sh_norm_q))
    else $error("sample-hold routing wrong");

  ctrl_read_zero_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    ctrl_read_s |=> prdata_q[9:0] == 10'h000 &&
      prdata_q[15:10] == $past(ctrl_q[15:10]))
    else $error("control readback wrong or bits 9:8 set");

  // a control write in the access phase
  sequence ctrl_write_s;
    apb_access_s and (i_pwrite && hit_ctrl);
  endsequence

  // a refused access: unmapped, misaligned or a read-only write
  sequence refused_s;
    apb_access_s and err;
  endsequence

  // mode flags lag their control bits by one clock, like the rest
  buf_mode_map_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    ##1 buf_idx_q == $past(ctrl_q[`ACB_BUF_IDX_BIT]))
    else $error("buffer mode flag wrong");

  scan_flag_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    ##1 scan_q == $past(ctrl_q[`ACB_SCAN_BIT]))
    else $error("scan enable flag wrong");

  // byte one carries every field, so its strobe decides the write
  ctrl_write_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (ctrl_write_s and i_pstrb[1]) |=>
      (ctrl_q[`ACB_POS_REF_MSB:`ACB_SCAN_BIT] ==
        $past(i_pwdata[`ACB_POS_REF_MSB:`ACB_SCAN_BIT])))
    else $error("control write did not land");

  // the unimplemented bits can never hold a one, written or not
  ctrl_unimpl_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    ##1 (ctrl_q & ~`ACB_CTRL_MASK) == 32'h0000_0000)
    else $error("unimplemented control bit set");

  // refused accesses answer with an error and change nothing
  refused_err_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    refused_s |=> pready_q && pslverr_q &&
      $stable(ctrl_q) && $stable(incfg_q))
    else $error("refused access not flagged or it wrote");

  // accepted accesses answer cleanly
  accept_ok_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (apb_access_s and !err) |=> pready_q && !pslverr_q)
    else $error("accepted access flagged as error");

  // read data stays zero while no answer stands, so stale data
  // never leaks onto a bus shared with other slaves
  prdata_idle_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    !pready_q |-> prdata_q == 32'h0000_0000)
    else $error("read data not zero outside answer");

endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the adc reference and buffer configuration block
`timescale 1ns/100ps
`include "acb_regs.svh"

module tb_top;
  // ==========================================================
  // stimulus, observed outputs and counters
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1; // held high from time zero
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic [3:0] i_pstrb = 4'hf;
  logic i_result_valid = 1'b0;
  logic [11:0] i_result = 12'h000;
  logic i_conv_done = 1'b0;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic [3:0] o_pos_ref_onehot;
  logic o_neg_ref_ext;
  logic o_sh_to_ground;
  logic o_sh_normal;
  logic o_buf_indexed;
  logic o_scan_active;
  logic [3:0] o_mux_a_chan;
  int n_errors = 0;
  int n_tests = 0;

  // 100 ns clock period
  always #50 i_mclk = ~i_mclk;

  acb_top u_acb_top (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_result_valid(i_result_valid), .i_result(i_result),
    .i_conv_done(i_conv_done), .o_pos_ref_onehot(o_pos_ref_onehot),
    .o_neg_ref_ext(o_neg_ref_ext), .o_sh_to_ground(o_sh_to_ground),
    .o_sh_normal(o_sh_normal), .o_buf_indexed(o_buf_indexed),
    .o_scan_active(o_scan_active), .o_mux_a_chan(o_mux_a_chan)
  );

  // ==========================================================
  // comparison and bus tasks
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    // no wait count is assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_pready !== 1'b1);
    q = o_prdata;
    err = o_pslverr;
    // the slave answers after exactly one wait state
    chk("wait_states", 32'h0000_0002, 32'(n));
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk("wr_slverr", 32'h0, 32'(e));
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk("rd_slverr", 32'h0, 32'(e));
    chk("prdata", exp, q);
  endtask

  // let the registered decoded outputs land
  task automatic settle();
    @(posedge i_mclk);
    #1;
  endtask

  task automatic push(input logic [11:0] v);
    @(posedge i_mclk);
    i_result_valid <= 1'b1;
    i_result <= v;
    @(posedge i_mclk);
    i_result_valid <= 1'b0;
  endtask

  // one conversion finished; chan steps at the sampling edge
  task automatic conv(input logic [3:0] exp);
    @(posedge i_mclk);
    i_conv_done <= 1'b1;
    @(posedge i_mclk);
    i_conv_done <= 1'b0;
    #1;
    chk("mux_chan", 32'(exp), 32'(o_mux_a_chan));
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog, far beyond the roughly 130 cycles the tests need
  initial begin
    #2_000_000;
    n_errors++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] q;
    logic e;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    settle();
    chk("onehot", 32'h1, 32'(o_pos_ref_onehot));
    chk("sh_normal", 32'h1, 32'(o_sh_normal));
    chk("scan", 32'h0, 32'(o_scan_active));
    chk("buf_idx", 32'h0, 32'(o_buf_indexed));
    chk("neg_ref", 32'h0, 32'(o_neg_ref_ext));
    chk("mux_chan", 32'h0, 32'(o_mux_a_chan));
    rd(`ACB_ADDR_CTRL, 32'h0000_0000);
    $display("test reset done");
    // every positive reference code
    for (int c = 0; c < 4; c++) begin
      wr(`ACB_ADDR_CTRL, 32'(c) << 14);
      settle();
      chk("onehot", 32'h1 << c, 32'(o_pos_ref_onehot));
      rd(`ACB_ADDR_CTRL, 32'(c) << 14);
    end
    $display("test pos_ref done");
    // all ones: implemented bits set, bits 9:8 still read zero
    wr(`ACB_ADDR_CTRL, 32'hffff_ffff);
    settle();
    chk("neg_ref", 32'h1, 32'(o_neg_ref_ext));
    chk("sh_gnd", 32'h1, 32'(o_sh_to_ground));
    chk("sh_normal", 32'h0, 32'(o_sh_normal));
    chk("buf_idx", 32'h1, 32'(o_buf_indexed));
    chk("scan", 32'h1, 32'(o_scan_active));
    rd(`ACB_ADDR_CTRL, 32'h0000_fc00);
    wr(`ACB_ADDR_CTRL, 32'h0000_0000);
    settle();
    chk("neg_ref", 32'h0, 32'(o_neg_ref_ext));
    chk("sh_gnd", 32'h0, 32'(o_sh_to_ground));
    chk("sh_normal", 32'h1, 32'(o_sh_normal));
    chk("buf_idx", 32'h0, 32'(o_buf_indexed));
    chk("scan", 32'h0, 32'(o_scan_active));
    $display("test fields done");
    // fifo order, then channel indexed slot
    push(12'habc);
    push(12'h123);
    rd(`ACB_ADDR_BUF_FIRST, 32'h0000_0abc);
    rd(`ACB_ADDR_BUF_FIRST + 12'h004, 32'h0000_0123);
    rd(`ACB_ADDR_STAT, 32'h0000_0200);
    wr(`ACB_ADDR_INCFG, 32'h0000_0005);
    wr(`ACB_ADDR_CTRL, 32'h0000_0800);
    settle();
    push(12'h5a5);
    rd(`ACB_ADDR_BUF_FIRST + 12'h014, 32'h0000_05a5);
    rd(`ACB_ADDR_STAT, 32'h0000_0005);
    $display("test buffer done");
    // scan over channels 2 and 7 with wrap, then back to single
    wr(`ACB_ADDR_INCFG, 32'h0084_0002);
    wr(`ACB_ADDR_CTRL, 32'h0000_0400);
    settle();
    chk("mux_chan", 32'h2, 32'(o_mux_a_chan));
    conv(4'h7);
    conv(4'h2);
    conv(4'h7);
    wr(`ACB_ADDR_CTRL, 32'h0000_0000);
    settle();
    chk("mux_chan", 32'h2, 32'(o_mux_a_chan));
    conv(4'h2);
    $display("test scan done");
    // unmapped address is refused and reads zero
    apb(1'b0, 12'h00c, 32'h0000_0000, q, e);
    chk("unmapped_err", 32'h1, 32'(e));
    chk("unmapped_data", 32'h0, q);
    // status is read only: the write is refused and leaves it alone
    apb(1'b1, `ACB_ADDR_STAT, 32'hffff_ffff, q, e);
    chk("ro_write_err", 32'h1, 32'(e));
    rd(`ACB_ADDR_STAT, 32'h0000_0002);
    $display("test unmapped done");
    stop_test();
  end
endmodule
